// >>> hw/xec_top.sv
/*
  Exception-entry control: chooses when reset, trap and interrupt
  exceptions start and which vector the sequencer fetches.
  Assumes all inputs but ARST_N synchronous to CLK_SYS; the sequencer pulses
  INSN_DONE at each instruction boundary and EXC_DONE when an
  exception entry has finished.
*/
`timescale 1ns/10ps
`include "xec_regs.svh"

module xec_top (
  input  wire logic                        CLK_SYS,
  input  wire logic                        ARST_N,
  input  wire logic                        RESET_PIN_N,
  input  wire logic                        WDT_OVF,
  input  wire logic                        TRAP_EXEC,
  input  wire logic [1:0]                  TRAP_NUM,
  input  wire logic                        INSN_DONE,
  input  wire logic                        EXC_DONE,
  input  wire logic                        I_BIT,
  input  wire xec_pkg::xec_req_s           REQ,
  output xec_pkg::xec_exc_s                EXC,
  output logic                             CHIP_RST,
  output logic                             EXC_ACTIVE
);

  xec_pkg::xec_state_e        state;
  xec_pkg::xec_state_e        next_state;
  logic [`XEC_CNT_W-1:0]      wdt_cnt;
  logic [`XEC_CNT_W-1:0]      next_wdt_cnt;
  xec_pkg::xec_req_s          pend;
  xec_pkg::xec_req_s          next_pend;
  xec_pkg::xec_req_s          clr;
  xec_pkg::xec_exc_s          next_exc;
  logic                       next_chip_rst;
  logic                       next_exc_active;
  logic [`XEC_IRQ_N-1:0]      irq_open;
  logic                       irq_found;
  logic [`XEC_IRQ_IDX_W-1:0]  irq_idx;
  logic                       int_take;
  logic [`XEC_VEC_W-1:0]      int_vec;
  xec_pkg::xec_req_s          int_clr;
  logic                       reset_req;

  function automatic logic [`XEC_ADDR_W-1:0] vec_addr(
    input logic [`XEC_VEC_W-1:0] vec
  );
    vec_addr = `XEC_ADDR_W'(vec) * `XEC_ADDR_W'(`XEC_VEC_BYTES);
  endfunction

  function automatic xec_pkg::xec_exc_s launch(
    input logic [`XEC_VEC_W-1:0] vec
  );
    launch.start = 1'b1;
    launch.vec   = vec;
    launch.addr  = vec_addr(vec);
  endfunction

  // Trap numbers select four consecutive vectors
  function automatic logic [`XEC_VEC_W-1:0] trap_vec(
    input logic [1:0] num
  );
    trap_vec = `XEC_VEC_TRAP + `XEC_VEC_W'(num);
  endfunction

  // Source index maps one to one onto the interrupt vectors
  function automatic logic [`XEC_VEC_W-1:0] irq_vec(
    input logic [`XEC_IRQ_IDX_W-1:0] idx
  );
    irq_vec = `XEC_VEC_IRQ + `XEC_VEC_W'(idx);
  endfunction

  // Mask bit gates only the ordinary sources
  assign irq_open = I_BIT ? '0 : pend.irq;

  xec_prio u_prio (
    .req   (irq_open),
    .found (irq_found),
    .idx   (irq_idx)
  );

  // Interrupt choice: non-maskable, then break, then the rest
  always_comb begin
    int_take = 1'b0;
    int_vec  = `XEC_VEC_RESET;
    int_clr  = '0;
    if (pend.nmi) begin
      int_take    = 1'b1;
      int_vec     = `XEC_VEC_NMI;
      int_clr.nmi = 1'b1;
    end else if (pend.brk) begin
      int_take    = 1'b1;
      int_vec     = `XEC_VEC_BRK;
      int_clr.brk = 1'b1;
    end else if (irq_found) begin
      int_take    = 1'b1;
      int_vec     = irq_vec(irq_idx);
      int_clr.irq = `XEC_IRQ_N'(1) << irq_idx;
    end
  end

  // Either reset source takes the chip back to reset hold
  assign reset_req = !RESET_PIN_N || WDT_OVF;

  // Watchdog stretch counter
  // A low pin freezes it, so the stretch still runs out afterwards
  always_comb begin
    next_wdt_cnt = wdt_cnt;
    if (WDT_OVF) begin
      next_wdt_cnt = `XEC_CNT_W'(`XEC_WDT_RST_CYC);
    end else if (RESET_PIN_N && wdt_cnt != '0) begin
      next_wdt_cnt = wdt_cnt - `XEC_CNT_W'(1);
    end
  end

  // Sequencing of exception entry
  always_comb begin
    next_state      = state;
    next_exc        = EXC;
    next_exc.start  = 1'b0;
    next_chip_rst   = 1'b0;
    next_exc_active = EXC_ACTIVE;
    clr             = '0;
    if (reset_req) begin
      // Reset wins over anything in flight
      next_state      = xec_pkg::XEC_HOLD;
      next_chip_rst   = 1'b1;
      next_exc_active = 1'b0;
    end else begin
      case (state)
        xec_pkg::XEC_HOLD: begin
          if (wdt_cnt != '0) begin
            // Chip stays in reset until the stretch has run out
            next_chip_rst = 1'b1;
          end else begin
            // Same entry for pin and watchdog
            next_exc        = launch(`XEC_VEC_RESET);
            next_exc_active = 1'b1;
            next_state      = xec_pkg::XEC_EXC;
          end
        end
        xec_pkg::XEC_RUN: begin
          if (TRAP_EXEC) begin
            // Trap has no mask term at all
            next_exc        = launch(trap_vec(TRAP_NUM));
            next_exc_active = 1'b1;
            next_state      = xec_pkg::XEC_EXC;
          end else if (INSN_DONE && int_take) begin
            // Interrupts wait for the instruction boundary
            next_exc        = launch(int_vec);
            next_exc_active = 1'b1;
            clr             = int_clr;
            next_state      = xec_pkg::XEC_EXC;
          end
        end
        xec_pkg::XEC_EXC: begin
          // Trap and boundary pulses are ignored until entry ends
          if (EXC_DONE) begin
            if (int_take) begin
              // Chain straight into the next pending interrupt
              next_exc = launch(int_vec);
              clr      = int_clr;
            end else begin
              next_exc_active = 1'b0;
              next_state      = xec_pkg::XEC_RUN;
            end
          end
        end
        default: begin
          // Unused code: fall back to reset hold
          next_state    = xec_pkg::XEC_HOLD;
          next_chip_rst = 1'b1;
        end
      endcase
    end
  end

  // Pending requests survive masking; a new request beats its own clear
  always_comb begin
    if (next_chip_rst) begin
      next_pend = '0;
    end else begin
      next_pend.nmi = (pend.nmi & ~clr.nmi) | REQ.nmi;
      next_pend.brk = (pend.brk & ~clr.brk) | REQ.brk;
      next_pend.irq = (pend.irq & ~clr.irq) | REQ.irq;
    end
  end

  // Stretch counter
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      wdt_cnt <= '0;
    end else begin
      wdt_cnt <= next_wdt_cnt;
    end
  end

  // Pending requests
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pend <= '0;
    end else begin
      pend <= next_pend;
    end
  end

  // Sequencer state and registered outputs
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state      <= xec_pkg::XEC_HOLD;
      EXC        <= '0;
      CHIP_RST   <= 1'b1;
      EXC_ACTIVE <= 1'b0;
    end else begin
      state      <= next_state;
      EXC        <= next_exc;
      CHIP_RST   <= next_chip_rst;
      EXC_ACTIVE <= next_exc_active;
    end
  end

endmodule

// >>> pkg/xec_regs.svh
/*
  Constants of the exception-entry control block: vector numbers,
  source counts and the watchdog reset stretch.
  Assumes a 100 MHz system clock and that it is included by bare name.
*/
`ifndef XEC_REGS_SVH
`define XEC_REGS_SVH

`define XEC_VEC_W        6
`define XEC_ADDR_W       16
`define XEC_IRQ_N        12
`define XEC_IRQ_IDX_W    4
`define XEC_VEC_RESET    6'h00
`define XEC_VEC_NMI      6'h07
`define XEC_VEC_TRAP     6'h08
`define XEC_VEC_BRK      6'h0c
`define XEC_VEC_IRQ      6'h0e
`define XEC_VEC_BYTES    2

`define XEC_CLK_NS       10
`define XEC_WDT_RST_NS   100
`define XEC_CNT_W        16
`define XEC_WDT_RST_CYC  ((`XEC_WDT_RST_NS + `XEC_CLK_NS - 1) / `XEC_CLK_NS)

`endif

// >>> pkg/xec_pkg.sv
/*
  Types of the exception-entry control block.
  Assumes xec_regs.svh is on the include path.
*/
`include "xec_regs.svh"

package xec_pkg;

  typedef enum logic [1:0] {
    XEC_HOLD = 2'b00,
    XEC_RUN  = 2'b01,
    XEC_EXC  = 2'b10
  } xec_state_e;

  typedef struct packed {
    logic                    nmi;
    logic                    brk;
    logic [`XEC_IRQ_N-1:0]   irq;
  } xec_req_s;

  typedef struct packed {
    logic                    start;
    logic [`XEC_VEC_W-1:0]   vec;
    logic [`XEC_ADDR_W-1:0]  addr;
  } xec_exc_s;

endpackage

// >>> hw/xec_prio.sv
/*
  Fixed-priority picker for the maskable interrupt requests.
  Assumes bit 0 is the highest priority source.
*/
`timescale 1ns/10ps
`include "xec_regs.svh"

module xec_prio (
  input  wire logic [`XEC_IRQ_N-1:0]     req,
  output logic                           found,
  output logic [`XEC_IRQ_IDX_W-1:0]      idx
);

  always_comb begin
    found = 1'b0;
    idx   = '0;
    // Walk down so the lowest index wins
    for (int i = `XEC_IRQ_N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = i[`XEC_IRQ_IDX_W-1:0];
      end
    end
  end

endmodule

// >>> dv/xec_seq_model.sv
/* Sequencer model: boundary and entry-end pulses; follows the block's start pulse. */
`timescale 1ns/10ps
module xec_seq_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic slow,
  output logic      insn_done,
  output logic      exc_done
);
  logic       busy;
  logic [3:0] cnt;
  // Slow mode stretches entry so late completion is exercised
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {busy, cnt, insn_done, exc_done} <= '0;
    end else begin
      insn_done <= !busy && !start && !insn_done;
      exc_done <= busy && cnt == 4'h1;
      busy <= start || (busy && cnt != 4'h0);
      cnt <= start ? (slow ? 4'h8 : 4'h2) : cnt - {3'h0, cnt != 4'h0};
    end
  end
endmodule

// >>> dv/xec_top_properties.sv
/* Port timing checker of xec_top; bound onto every xec_top instance. */
`timescale 1ns/10ps
module xec_chk (
  input wire logic              CLK_SYS,
  input wire logic              ARST_N,
  input wire logic              RESET_PIN_N,
  input wire logic              WDT_OVF,
  input wire logic              TRAP_EXEC,
  input wire logic [1:0]        TRAP_NUM,
  input wire logic              INSN_DONE,
  input wire logic              EXC_DONE,
  input wire logic              I_BIT,
  input wire xec_pkg::xec_exc_s EXC,
  input wire logic              CHIP_RST,
  input wire logic              EXC_ACTIVE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  sequence vec0; EXC.start && EXC.vec == 6'h00; endsequence
  sequence wdt_hold; CHIP_RST [*8] ##1 CHIP_RST [*3]; endsequence
  chk_pin_hold: assert property (!RESET_PIN_N |=> CHIP_RST) else $error("pin");
  chk_rst_prio: assert property (CHIP_RST |-> !EXC.start) else $error("prio");
  chk_pin_release: assert property ($rose(RESET_PIN_N) |=> vec0) else $error("rel");
  chk_wdt_reset: assert property (WDT_OVF |=> wdt_hold ##1 vec0) else $error("wdt");
  chk_trap_vec: assert property (TRAP_EXEC && !EXC_ACTIVE && !CHIP_RST && RESET_PIN_N
    && !WDT_OVF |=> EXC.start && EXC.vec == 6'h08 + $past(TRAP_NUM)) else $error("trap");
  chk_addr_pair: assert property (EXC.start |-> EXC.addr == {9'h000, EXC.vec, 1'b0})
    else $error("addr");
  chk_mask_gate: assert property (EXC.start && EXC.vec >= 6'h0e |-> !$past(I_BIT))
    else $error("mask");
  chk_irq_bound: assert property (EXC.start && (EXC.vec == 6'h07 || EXC.vec >= 6'h0c)
    |-> $past(INSN_DONE || EXC_DONE)) else $error("bound");
  chk_active_pair: assert property (EXC.start |-> EXC_ACTIVE) else $error("active");
  chk_active_end: assert property ($fell(EXC_ACTIVE) && !CHIP_RST |-> $past(EXC_DONE))
    else $error("end");
endmodule
bind xec_top xec_chk u_chk (.*);

// >>> dv/xec_top_tb.sv
/* Random and corner bench of xec_top; needs the sequencer model and bound checker. */
`timescale 1ns/10ps
module xec_top_tb;
  logic CLK_SYS, ARST_N, RESET_PIN_N, WDT_OVF, TRAP_EXEC, I_BIT, INSN_DONE, EXC_DONE;
  logic CHIP_RST, EXC_ACTIVE, slow;
  logic [1:0] TRAP_NUM;
  xec_pkg::xec_req_s REQ;
  xec_pkg::xec_exc_s EXC;
  int err_count, n_compared, seed, k;
  always #5 CLK_SYS = ~CLK_SYS;
  xec_top DUT (.*);
  xec_seq_model u_seq (.clk(CLK_SYS), .rst_n(ARST_N), .start(EXC.start), .slow(slow),
    .insn_done(INSN_DONE), .exc_done(EXC_DONE));
  function automatic logic [5:0] vec_of(input int base, input int i);
    return 6'(base + i);
  endfunction
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fail(input string m);
    err_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  // Bounded so a hung sequencer still reaches the verdict
  task automatic run_wait;
    repeat (50) begin
      @(negedge CLK_SYS);
      if (EXC_ACTIVE === 1'b0 && CHIP_RST === 1'b0) return;
    end
    fail("no idle");
    finish_test;
  endtask
  task automatic chk_start(input logic [5:0] exp);
    repeat (60) begin
      @(negedge CLK_SYS);
      if (EXC.start === 1'b1) begin
        n_compared++;
        if (EXC.vec !== exp || EXC.addr !== {9'h000, exp, 1'b0}) fail("wrong vector");
        return;
      end
    end
    fail("no start");
    finish_test;
  endtask
  task automatic chk_none(input int n);
    n_compared++;
    repeat (n) begin
      @(negedge CLK_SYS);
      if (EXC.start !== 1'b0) fail("stray start");
    end
  endtask
  task automatic pulse(input logic [13:0] v);
    @(posedge CLK_SYS) REQ <= v;
    @(posedge CLK_SYS) REQ <= '0;
  endtask
  initial begin
    {CLK_SYS, ARST_N, WDT_OVF, TRAP_EXEC, I_BIT, slow, TRAP_NUM, REQ} = '0;
    RESET_PIN_N = 1'b1;
    err_count = 0;
    n_compared = 0;
    seed = 32'h8a12;
    repeat (3) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    chk_start(6'h00);
    for (int n = 0; n < 6; n++) begin
      run_wait;
      k = (n < 4) ? n : $unsigned($random(seed)) % 4;
      @(posedge CLK_SYS);
      slow <= n[0];
      I_BIT <= 1'($random(seed));
      TRAP_NUM <= 2'(k);
      TRAP_EXEC <= 1'b1;
      @(posedge CLK_SYS) TRAP_EXEC <= 1'b0;
      chk_start(vec_of(8, k));
    end
    k = $unsigned($random(seed)) % 3;
    run_wait;
    @(posedge CLK_SYS) I_BIT <= 1'b1;
    pulse(14'h0001 << k);
    chk_none(12);
    pulse(14'h2000);
    chk_start(6'h07);
    run_wait;
    pulse(14'h1000);
    chk_start(6'h0c);
    run_wait;
    pulse(14'h0208);
    @(posedge CLK_SYS) I_BIT <= 1'b0;
    chk_start(vec_of(14, k));
    chk_start(vec_of(14, 3));
    chk_start(vec_of(14, 9));
    run_wait;
    @(posedge CLK_SYS) RESET_PIN_N <= 1'b0;
    pulse(14'h2000);
    chk_none(5);
    @(posedge CLK_SYS) RESET_PIN_N <= 1'b1;
    chk_start(6'h00);
    run_wait;
    chk_none(6);
    @(posedge CLK_SYS) WDT_OVF <= 1'b1;
    @(posedge CLK_SYS) WDT_OVF <= 1'b0;
    chk_start(6'h00);
    run_wait;
    finish_test;
  end
endmodule
